// ### rtl/ecgc_pkg.sv
// Behaviour
// (RULE_01) Cascade joins both cancellers, 128 ms tail
// (RULE_02) Cascade: only canceller A timeslot active; the code still passes canceller B timeslot data under canceller A's controls
// (RULE_03) Cascade bit lives in canceller A control
// (RULE_04) Host keeps canceller B cascade bit zero
// (RULE_05) Four states: mute, bypass, frozen, running
// (RULE_06) Receive mute feeds quiet; send mute quiets output
// (RULE_07) Quiet code follows selected PCM coding
// (RULE_08) Back-to-back: canceller A second register send_silence_bit
// (RULE_09) Host keeps B mute bits zero when paired
// (RULE_10) Bypass passes data, zeroes coefficients
// (RULE_11) Frozen holds coefficients, running updates them
// (RULE_12) Receive two frames, send three, bypass two
// (RULE_13) Four streams, channel n for canceller n
// (RULE_14) Group g owns channels 2g, 2g+1
// (RULE_15) Bit clock 4.096 MHz, data 2.048 Mb/s
// (RULE_16) Frame pulse format detected automatically
// (RULE_17) First format samples rising edge, three quarters
// (RULE_18) Second format samples falling edge, halfway
// (RULE_19) Each canceller owns 32 register locations
// (RULE_20) Reset clears main regs, tristates outputs
// (RULE_21) Host waits lock, then sets power bits
// (RULE_22) Power bit rise reinitialises group, two frames
// (RULE_23) Powered-down group passes data, two frames
// (RULE_24) Canceller block base is n times 20h
// (RULE_25) Host waits two frames before control writes
package ecgc_pkg;
  localparam int NCH = 32;
  localparam int NGRP = 16;
  localparam int AD_SEL = 10;
  localparam int CH_HI = 9;
  localparam int CH_LO = 5;
  localparam int OFF_HI = 4;
  localparam int MAIN_LSB = 4;
  localparam logic [10:0] MAIN_BASE = 11'h400;
  localparam logic [10:0] CODING_ADDR = 11'h410;
  localparam logic [4:0] OFF_CTL1 = 5'h00;
  localparam logic [4:0] OFF_CTL2 = 5'h01;
  localparam logic [4:0] OFF_STAT = 5'h02;
  localparam int HC_CH_HI = 8;
  localparam int HC_CH_LO = 4;
  localparam int HC_BIT_HI = 3;
  localparam int HC_BIT_LO = 1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RX_DLY = 2'h2;
  localparam logic [1:0] TX_DLY = 2'h3;
  localparam logic [1:0] BYP_DLY = 2'h2;
  localparam logic [1:0] INIT_FRAMES = 2'h2;
  localparam logic [7:0] Q_LIN = 8'h00;
  localparam logic [7:0] Q_SM = 8'h80;
  localparam logic [7:0] Q_MU = 8'hFF;
  localparam logic [7:0] Q_A = 8'hD5;
  localparam logic [7:0] CTL_RST = 8'h00;

  typedef enum logic [1:0] {CODE_LIN, CODE_SM, CODE_MU, CODE_A} ecgc_coding_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic b2b;
    logic rsv_pad;
    logic bypass;
    logic [1:0] rsv_lo;
    logic cascade;
  } ecgc_ctl1_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic freeze;
    logic send_mute;
    logic recv_mute;
  } ecgc_ctl2_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic busy;
    logic tail128;
    logic adapting;
    logic coef_nz;
  } ecgc_stat_t;
endpackage

// ### rtl/ecgc_top.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
module ecgc_top import ecgc_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [10:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_bit_clock,
  input wire logic frame_pulse_input,
  input wire logic rin_data,
  input wire logic sin_data,
  output logic rout_data,
  output logic rout_oe,
  output logic sout_data,
  output logic sout_oe
);
  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic bclk_d_r;
  logic bclk, fp, rin_s, sin_s, fall, rise;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      bclk_d_r <= 1'b0;
    end else begin
      meta_r <= {serial_bit_clock, frame_pulse_input, rin_data, sin_data};
      sync_r <= meta_r;
      bclk_d_r <= sync_r[3];
    end
  end

  assign bclk = sync_r[3];
  assign fp = sync_r[2];
  assign rin_s = sync_r[1];
  assign sin_s = sync_r[0];
  assign fall = bclk_d_r & ~bclk;
  assign rise = ~bclk_d_r & bclk;

  // ------------------------------------------------------------
  // Frame timing and format detection
  // ------------------------------------------------------------
  logic [8:0] hcnt_r, hcnt_nxt;
  logic [1:0] bank_r, ob;
  logic fmt_gci_r, act_prev_r, frame_seen_r;
  logic fp_act, frame_start;

  assign fp_act = (fp == fmt_gci_r);
  assign frame_start = fall & fp_act;
  assign hcnt_nxt = fp_act ? 9'h000 : hcnt_r + 9'h001;
  assign ob = frame_start ? bank_r + 2'h1 : bank_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hcnt_r <= 9'h000;
      bank_r <= 2'h0;
      frame_seen_r <= 1'b0;
    end else if (fall) begin
      hcnt_r <= hcnt_nxt;
      if (fp_act) begin
        bank_r <= bank_r + 2'h1;
        frame_seen_r <= 1'b1;
      end
    end
  end

  // A pulse seen on two edges in a row means the idle level is wrong
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fmt_gci_r <= 1'b0;
      act_prev_r <= 1'b0;
    end else if (fall) begin
      act_prev_r <= fp_act & ~act_prev_r;
      if (fp_act && act_prev_r) begin
        fmt_gci_r <= ~fmt_gci_r; // RULE_16
      end
    end
  end

  // ------------------------------------------------------------
  // Control and status registers
  // ------------------------------------------------------------
  ecgc_ctl1_t ctl1_r [NCH];
  ecgc_ctl2_t ctl2_r [NCH];
  logic [NGRP-1:0] pwr_r;
  logic [NGRP-1:0] pwr_rise;
  logic [1:0] busy_r [NGRP];
  logic [1:0] coding_r;
  logic [NCH-1:0] coef_nz_r;
  logic [7:0] reg_rdata_r, rd_nxt;
  logic [4:0] rch;
  logic [4:0] roff;
  logic main_sel, chan_sel;

  assign rch = reg_addr[CH_HI:CH_LO];
  assign roff = reg_addr[OFF_HI:0];
  assign chan_sel = ~reg_addr[AD_SEL]; // RULE_24
  assign main_sel = reg_addr[AD_SEL:MAIN_LSB] == MAIN_BASE[AD_SEL:MAIN_LSB];

  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      pwr_rise[g] = reg_wr & main_sel & (reg_addr[MAIN_LSB-1:0] == g[MAIN_LSB-1:0]) & reg_wdata[0] & ~pwr_r[g];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_r <= '0; // RULE_20
      coding_r <= 2'h0;
    end else if (reg_wr) begin
      if (main_sel) begin
        pwr_r[reg_addr[MAIN_LSB-1:0]] <= reg_wdata[0];
      end
      if (reg_addr == CODING_ADDR) begin
        coding_r <= reg_wdata[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int g = 0; g < NGRP; g++) begin
        busy_r[g] <= 2'h0;
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        if (pwr_rise[g]) begin
          busy_r[g] <= INIT_FRAMES; // RULE_22
        end else if (frame_start && busy_r[g] != 2'h0) begin
          busy_r[g] <= busy_r[g] - 2'h1;
        end
      end
    end
  end

  // Per canceller block of 32 locations, base is channel times 20h
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctl1_r[c] <= CTL_RST;
        ctl2_r[c] <= CTL_RST;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (pwr_rise[c/2] || busy_r[c/2] != 2'h0) begin
          ctl1_r[c] <= CTL_RST; // RULE_22
          ctl2_r[c] <= CTL_RST;
        end else if (reg_wr && chan_sel && rch == c[4:0]) begin
          if (roff == OFF_CTL1) begin
            ctl1_r[c] <= reg_wdata; // RULE_19
          end
          if (roff == OFF_CTL2) begin
            ctl2_r[c] <= reg_wdata;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Per channel effective state
  // ------------------------------------------------------------
  logic [NCH-1:0] byp_ch, frz_ch, mr_ch, ms_ch, pwr_ch, busy_ch, tail_ch;
  ecgc_stat_t stat_ch [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // Paired modes steer both channels from canceller A
      if (ctl1_r[(c/2)*2].cascade || ctl1_r[(c/2)*2].b2b) begin
        byp_ch[c] = ctl1_r[(c/2)*2].bypass; // RULE_03
        frz_ch[c] = ctl2_r[(c/2)*2].freeze;
        mr_ch[c] = ctl2_r[(c/2)*2].recv_mute; // RULE_08
        ms_ch[c] = ctl2_r[(c/2)*2].send_mute;
      end else begin
        byp_ch[c] = ctl1_r[c].bypass; // RULE_05
        frz_ch[c] = ctl2_r[c].freeze;
        mr_ch[c] = ctl2_r[c].recv_mute;
        ms_ch[c] = ctl2_r[c].send_mute;
      end
      pwr_ch[c] = pwr_r[c/2]; // RULE_14
      busy_ch[c] = busy_r[c/2] != 2'h0;
      tail_ch[c] = ctl1_r[(c/2)*2].cascade & ((c % 2) == 0); // RULE_01
      stat_ch[c] = '0;
      stat_ch[c].busy = busy_ch[c];
      stat_ch[c].tail128 = tail_ch[c];
      stat_ch[c].adapting = pwr_ch[c] & ~busy_ch[c] & ~byp_ch[c] & ~frz_ch[c];
      stat_ch[c].coef_nz = coef_nz_r[c];
    end
  end

  // Coefficient state, updated once per frame
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      coef_nz_r <= '0;
    end else if (frame_start) begin
      for (int c = 0; c < NCH; c++) begin
        if (!pwr_ch[c] || busy_ch[c] || byp_ch[c]) begin
          coef_nz_r[c] <= 1'b0; // RULE_10
        end else if (!frz_ch[c]) begin
          coef_nz_r[c] <= 1'b1; // RULE_11
        end
      end
    end
  end

  always_comb begin
    rd_nxt = 8'h00;
    if (chan_sel) begin
      case (roff)
        OFF_CTL1: rd_nxt = ctl1_r[rch];
        OFF_CTL2: rd_nxt = ctl2_r[rch];
        OFF_STAT: rd_nxt = stat_ch[rch];
        default: rd_nxt = 8'h00;
      endcase
    end else if (main_sel) begin
      rd_nxt = {7'h00, pwr_r[reg_addr[MAIN_LSB-1:0]]};
    end else if (reg_addr == CODING_ADDR) begin
      rd_nxt = {fmt_gci_r, 5'h00, coding_r};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_nxt : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Serial capture into frame banks
  // ------------------------------------------------------------
  logic [7:0] rx_mem [128];
  logic [7:0] tx_mem [128];
  logic [6:0] rsh_r, ssh_r;
  logic [8:0] samp_pos;
  logic [4:0] samp_ch;
  logic [2:0] samp_bit;
  logic [6:0] widx;
  logic samp_ev, wr_byte, rx_quiet;
  logic [7:0] quiet;

  always_comb begin
    case (ecgc_coding_t'(coding_r))
      CODE_LIN: quiet = Q_LIN; // RULE_07
      CODE_SM: quiet = Q_SM;
      CODE_MU: quiet = Q_MU;
      CODE_A: quiet = Q_A;
      default: quiet = Q_LIN;
    endcase
  end

  // Two bit clock periods per data bit; bit cell spans two falling edges
  assign samp_ev = fmt_gci_r ? (fall & ~fp_act & ~hcnt_r[0]) : (rise & hcnt_r[0]); // RULE_17 RULE_18 RULE_15
  assign samp_pos = fmt_gci_r ? hcnt_r + 9'h001 : hcnt_r;
  assign samp_ch = samp_pos[HC_CH_HI:HC_CH_LO]; // RULE_13
  assign samp_bit = samp_pos[HC_BIT_HI:HC_BIT_LO];
  assign widx = {bank_r, samp_ch};
  assign wr_byte = samp_ev & (samp_bit == LAST_BIT);
  assign rx_quiet = mr_ch[samp_ch] & pwr_ch[samp_ch] & ~byp_ch[samp_ch];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsh_r <= 7'h00;
      ssh_r <= 7'h00;
    end else if (samp_ev) begin
      rsh_r <= {rsh_r[5:0], rin_s};
      ssh_r <= {ssh_r[5:0], sin_s};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_byte) begin
      rx_mem[widx] <= rx_quiet ? quiet : {rsh_r, rin_s}; // RULE_06
      tx_mem[widx] <= {ssh_r, sin_s};
    end
  end

  // ------------------------------------------------------------
  // Serial output from delayed banks
  // ------------------------------------------------------------
  logic [4:0] o_ch;
  logic [2:0] o_bit;
  logic [1:0] tdly;
  logic [7:0] rbyte, sbyte;
  logic out_ev, tx_quiet;
  logic rout_r, sout_r, rout_oe_r, sout_oe_r;

  assign out_ev = fall & ~hcnt_nxt[0];
  assign o_ch = hcnt_nxt[HC_CH_HI:HC_CH_LO];
  assign o_bit = hcnt_nxt[HC_BIT_HI:HC_BIT_LO];
  assign tdly = (!pwr_ch[o_ch] || byp_ch[o_ch]) ? BYP_DLY : TX_DLY; // RULE_12 RULE_23
  assign tx_quiet = ms_ch[o_ch] & pwr_ch[o_ch] & ~byp_ch[o_ch];
  assign rbyte = rx_mem[{ob - RX_DLY, o_ch}]; // RULE_12
  assign sbyte = tx_quiet ? quiet : tx_mem[{ob - tdly, o_ch}]; // RULE_06 RULE_02

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rout_r <= 1'b0;
      sout_r <= 1'b0;
      rout_oe_r <= 1'b0; // RULE_20
      sout_oe_r <= 1'b0;
    end else begin
      rout_oe_r <= frame_seen_r;
      sout_oe_r <= frame_seen_r;
      if (out_ev) begin
        rout_r <= rbyte[LAST_BIT - o_bit];
        sout_r <= sbyte[LAST_BIT - o_bit];
      end
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign rout_data = rout_r;
  assign sout_data = sout_r;
  assign rout_oe = rout_oe_r;
  assign sout_oe = sout_oe_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_cascade_join;
    (frame_start && ctl1_r[6].cascade) |=> (coef_nz_r[7] == coef_nz_r[6]);
  endproperty
  a_cascade_join: assert property (p_cascade_join) else $error("cascade halves diverge"); // RULE_01

  property p_rx_mute;
    (wr_byte && rx_quiet) |=> (rx_mem[$past(widx)] == $past(quiet));
  endproperty
  a_rx_mute: assert property (p_rx_mute) else $error("receive mute not quiet"); // RULE_06

  property p_quiet_mu;
    (out_ev && tx_quiet && coding_r == CODE_MU) |=> sout_r;
  endproperty
  a_quiet_mu: assert property (p_quiet_mu) else $error("mu-law quiet bit not one"); // RULE_07

  property p_bypass_zero;
    (frame_start && byp_ch[4]) |=> !coef_nz_r[4];
  endproperty
  a_bypass_zero: assert property (p_bypass_zero) else $error("bypass left coefficients"); // RULE_10

  property p_frozen;
    (frame_start && frz_ch[10] && !byp_ch[10] && pwr_ch[10] && !busy_ch[10]) |=> $stable(coef_nz_r[10]);
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen coefficients moved"); // RULE_11

  property p_fmt_flip;
    (fall && fp_act && act_prev_r) |=> (fmt_gci_r != $past(fmt_gci_r));
  endproperty
  a_fmt_flip: assert property (p_fmt_flip) else $error("format not reclassified"); // RULE_16

  property p_init;
    pwr_rise[0] |=> (busy_r[0] == INIT_FRAMES) && (ctl1_r[1] == CTL_RST) ##1 (ctl2_r[0] == CTL_RST);
  endproperty
  a_init: assert property (p_init) else $error("group init missing"); // RULE_22

  property p_map_rw;
    (reg_wr && reg_addr == 11'h0A1 && busy_r[2] == 2'h0 && !pwr_rise[2]) ##1 !reg_wr
      ##1 (reg_rd && reg_addr == 11'h0A1) |=> (reg_rdata_r == $past(reg_wdata, 3));
  endproperty
  a_map_rw: assert property (p_map_rw) else $error("channel block readback wrong"); // RULE_19

  property p_tx_dly;
    (out_ev && pwr_ch[o_ch] && !byp_ch[o_ch] && !tx_quiet)
      |=> (sout_r === $past(tx_mem[{ob - TX_DLY, o_ch}][LAST_BIT - o_bit]));
  endproperty
  a_tx_dly: assert property (p_tx_dly) else $error("send delay not three frames"); // RULE_12

  c_cascade: cover property (frame_start && ctl1_r[6].cascade && pwr_r[3]);
  c_gci: cover property (fall && fp_act && act_prev_r);
  c_quiet: cover property (out_ev && tx_quiet);
  c_init: cover property (pwr_rise[0] ##1 busy_r[0] == INIT_FRAMES);
endmodule // ecgc_top

// ### verification/ecgc_tdm_partner.sv
`timescale 1ns/1ns
// ----------------------------------------
// Serial highway model
// ----------------------------------------
module ecgc_tdm_partner (
  output logic serial_bit_clock,
  output logic frame_pulse_input,
  output logic rin_data,
  output logic sin_data,
  input wire logic rout_data,
  input wire logic sout_data,
  input wire logic gci_mode,
  output logic [255:0] rout_cap,
  output logic [255:0] sout_cap,
  output int frame_no
);
  logic [255:0] rout_work;
  logic [255:0] sout_work;
  logic [7:0] rin_byte;
  logic [7:0] sin_byte;
  int ch;
  int bt;

  initial begin
    serial_bit_clock = 1'b1;
    frame_pulse_input = 1'b1;
    rin_data = 1'b1;
    sin_data = 1'b1;
    rout_work = '0;
    sout_work = '0;
    rout_cap = '0;
    sout_cap = '0;
    frame_no = -1;
    forever begin
      // 512 clock periods a frame, two per bit
      for (int h = 0; h < 512; h++) begin
        ch = h / 16;
        bt = (h / 2) % 8;
        #20 serial_bit_clock = 1'b0;
        if (h == 0) begin
          rout_cap = rout_work;
          sout_cap = sout_work;
          frame_no = frame_no + 1;
        end
        rin_byte = {frame_no[2:0], ch[4:0]};
        sin_byte = {frame_no[2:0] + 3'h4, ch[4:0]};
        if (h % 2 == 0) begin
          rin_data = rin_byte[7 - bt];
          sin_data = sin_byte[7 - bt];
        end else begin
          rout_work[ch * 8 + 7 - bt] = rout_data;
          sout_work[ch * 8 + 7 - bt] = sout_data;
        end
        #20 serial_bit_clock = 1'b1;
        // Pulse over the frame boundary edge, low or high by format
        frame_pulse_input = gci_mode ? (h == 511) : (h != 511);
      end
    end
  end
endmodule // ecgc_tdm_partner

// ### verification/tb_ecgc_top.sv
`timescale 1ns/1ns
module tb_ecgc_top import ecgc_pkg::*; ;
  logic sys_clk, resetn, reg_wr, reg_rd, serial_bit_clock, frame_pulse_input;
  logic rin_data, sin_data, rout_data, rout_oe, sout_data, sout_oe, gci_mode;
  logic [10:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [255:0] rout_cap, sout_cap;
  logic [7:0] qtab [4] = '{Q_LIN, Q_SM, Q_MU, Q_A};
  int frame_no, fail_count, num_checks, f0, ff;

  ecgc_top ecgc_top_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_bit_clock(serial_bit_clock),
    .frame_pulse_input(frame_pulse_input), .rin_data(rin_data), .sin_data(sin_data),
    .rout_data(rout_data), .rout_oe(rout_oe), .sout_data(sout_data), .sout_oe(sout_oe));
  ecgc_tdm_partner ecgc_tdm_partner_i (.serial_bit_clock(serial_bit_clock),
    .frame_pulse_input(frame_pulse_input), .rin_data(rin_data), .sin_data(sin_data),
    .rout_data(rout_data), .sout_data(sout_data), .gci_mode(gci_mode), .rout_cap(rout_cap),
    .sout_cap(sout_cap), .frame_no(frame_no));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [10:0] ad(input int n, input logic [4:0] off);
    return {1'b0, n[4:0], off};
  endfunction
  function automatic logic [7:0] pr(input int f, input int c);
    return {f[2:0], c[4:0]};
  endfunction
  function automatic logic [7:0] ps(input int f, input int c);
    return {f[2:0] + 3'h4, c[4:0]};
  endfunction
  function automatic logic [7:0] ro(input int c);
    return rout_cap[c * 8 +: 8];
  endfunction
  function automatic logic [7:0] so(input int c);
    return sout_cap[c * 8 +: 8];
  endfunction

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_frame(input int k);
    wait (frame_no == k);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("TB: checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #(16 * 20480);
    fail_count++;
    $display("ERROR watchdog expected done seen timeout");
    give_verdict;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gci_mode = 1'b0;
    fail_count = 0;
    num_checks = 0;
    f0 = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(ad(5, OFF_CTL1), v);
    check8("ctl1 ch5", CTL_RST, v);
    check8("oe reset", 8'h00, {6'h00, rout_oe, sout_oe});
    rd(MAIN_BASE + 11'h001, v);
    check8("main g1", 8'h00, v);
    wr(ad(5, OFF_CTL2), 8'h5A);
    rd(ad(5, OFF_CTL2), v);
    check8("ctl2 ch5", 8'h5A, v);
    wr(ad(5, 5'h03), 8'hA5);
    rd(ad(5, 5'h03), v);
    check8("unmapped", 8'h00, v);
    $display("TB: test reset_map done");
    for (int g = 0; g < NGRP; g++) if (g != 1) wr(MAIN_BASE + 11'(g), 8'h01);
    rd(ad(0, OFF_STAT), v);
    check8("busy ch0", 8'h08, v & 8'h08);
    wr(ad(1, OFF_CTL2), 8'h04);
    rd(ad(1, OFF_CTL2), v);
    check8("busy write", 8'h00, v);
    for (int k = 1; k < 6 && f0 == 0; k++) begin
      wait_frame(k);
      rd(ad(0, OFF_STAT), v);
      if (v[3] === 1'b0) f0 = k;
    end
    check8("init frames", 8'h01, {7'h0, f0 > 0 && f0 <= 3});
    wr(CODING_ADDR, 8'h00);
    wr(ad(0, OFF_CTL2), 8'h03);
    rd(ad(5, OFF_CTL2), v);
    check8("reinit ch5", 8'h00, v);
    wr(ad(4, OFF_CTL1), 8'h08);
    wr(ad(4, OFF_CTL2), 8'h03);
    wr(ad(6, OFF_CTL1), 8'h01);
    wr(ad(6, OFF_CTL2), 8'h02);
    wr(ad(8, OFF_CTL1), 8'h20);
    wr(ad(9, OFF_CTL1), 8'h20);
    wr(ad(9, OFF_CTL2), 8'h00);
    wr(ad(8, OFF_CTL2), 8'h01);
    wr(ad(10, OFF_CTL2), 8'h04);
    $display("TB: test power_up done");
    for (int i = 1; i < 7; i++) begin
      wait_frame(f0 + i);
      if (i >= 3) check8("rout quiet ch0", qtab[i - 3], ro(0));
      if (i <= 3) wr(CODING_ADDR, {6'h00, 2'(i)});
    end
    $display("TB: test quiet_codes done");
    wait_frame(f0 + 7);
    ff = f0 + 6;
    check8("rout ch1", pr(ff - 2, 1), ro(1));
    check8("sout ch1", ps(ff - 3, 1), so(1));
    check8("sout ch0", Q_A, so(0));
    check8("rout ch4", pr(ff - 2, 4), ro(4));
    check8("sout ch4", ps(ff - 2, 4), so(4));
    check8("rout ch2", pr(ff - 2, 2), ro(2));
    check8("sout ch2", ps(ff - 2, 2), so(2));
    check8("rout ch6", pr(ff - 2, 6), ro(6));
    check8("sout ch6", Q_A, so(6));
    check8("rout ch8", Q_A, ro(8));
    check8("sout ch8", ps(ff - 3, 8), so(8));
    check8("oe", 8'h03, {6'h00, rout_oe, sout_oe});
    rd(ad(6, OFF_STAT), v);
    check8("tail ch6", 8'h04, v & 8'h04);
    rd(ad(4, OFF_STAT), v);
    check8("coef ch4", 8'h00, v & 8'h01);
    rd(ad(10, OFF_STAT), v);
    check8("adapt ch10", 8'h00, v & 8'h02);
    rd(ad(1, OFF_STAT), v);
    check8("adapt ch1", 8'h02, v & 8'h02);
    rd(CODING_ADDR, v);
    check8("coding", 8'h03, v);
    $display("TB: test datapath done");
    @(posedge sys_clk);
    gci_mode <= 1'b1;
    wait_frame(f0 + 12);
    ff = f0 + 11;
    check8("gci rout ch1", pr(ff - 2, 1), ro(1));
    check8("gci sout ch1", ps(ff - 3, 1), so(1));
    rd(CODING_ADDR, v);
    check8("gci coding", 8'h83, v);
    $display("TB: test gci_format done");
    give_verdict;
  end
endmodule // tb_ecgc_top
